/* File: rtl/ipc_consts.vh */
// Constants for the pending-clear and priority block.
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH
`define IPC_ADDR_W 12
`define IPC_NUM_LINES 32
`define IPC_NUM_PRI_LINES 12
`define IPC_PRI_W 2
`define IPC_VEC_FIRST 16
`define IPC_VEC_LAST 47
`define IPC_OFF_ENABLE_SET 12'h100
`define IPC_OFF_ENABLE_CLEAR 12'h180
`define IPC_OFF_PENDING_SET 12'h200
`define IPC_OFF_PENDING_CLEAR 12'h280
`define IPC_OFF_PRIORITY0 12'h400
`define IPC_OFF_PRIORITY1 12'h404
`define IPC_OFF_PRIORITY2 12'h408
`define IPC_OFF_IRQ_STATUS 12'h600
`define IPC_OFF_IRQ_CLEAR 12'h604
`define IPC_OFF_IRQ_ENABLE 12'h608
`define IPC_PRI_LSB 6
`define IPC_RESET_WORD 32'h0000_0000
`define IPC_EVT_W 2
`define IPC_EVT_PEND_ROSE 0
`define IPC_EVT_PEND_CLEARED 1
`endif

/* File: rtl/ipc_pend_cell.v */
// One interrupt line's pending and enable state.
`timescale 1ns/1ps
`default_nettype none
module ipc_pend_cell (
  // Clock and reset
  input wire sys_clk,
  input wire arst_n,
  // Controls
  input wire hw_req,
  input wire pend_set,
  input wire pend_clr,
  input wire ena_set,
  input wire ena_clr,
  // State
  output reg pend_q,
  output reg ena_q
);
  // Setting wins over clearing so a request landing with a clear is kept.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      ena_q <= 1'b0;
    end else begin
      if (hw_req || pend_set) begin
        pend_q <= 1'b1;
      end else if (pend_clr) begin
        pend_q <= 1'b0;
      end
      if (ena_set) begin
        ena_q <= 1'b1;
      end else if (ena_clr) begin
        ena_q <= 1'b0;
      end
    end
  end
endmodule // ipc_pend_cell
`default_nettype wire

/* File: rtl/ipc_arbiter.v */
// Picks the most urgent enabled pending line among those with a priority field.
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"
module ipc_arbiter (
  // Candidates
  input wire [`IPC_NUM_PRI_LINES-1:0] active,
  input wire [`IPC_NUM_PRI_LINES*`IPC_PRI_W-1:0] prio_flat,
  // Choice
  output reg win_valid,
  output reg [3:0] win_line,
  output reg [`IPC_PRI_W-1:0] win_prio
);
  integer i;
  reg [`IPC_PRI_W-1:0] p;
  // Strictly smaller wins, so ties go to the lower line number.
  always @* begin
    win_valid = 1'b0;
    win_line = 4'h0;
    win_prio = 2'h3;
    p = 2'h0;
    for (i = 0; i < `IPC_NUM_PRI_LINES; i = i + 1) begin
      p = prio_flat[i*`IPC_PRI_W +: `IPC_PRI_W];
      if (active[i] && (!win_valid || p < win_prio)) begin
        win_valid = 1'b1;
        win_line = i[3:0];
        win_prio = p;
      end
    end
  end
endmodule // ipc_arbiter
`default_nettype wire

/* File: rtl/ipc_top.v */
// Pending-clear, pending-set and enable registers for 32 interrupt lines, priority registers for lines 0-11.
// Overview of operation
// - Bit n maps to line n, vectors 16-47.
// - Writing one clears pending; zero leaves it.
// - Reading pending-clear returns current pending status.
// - Four 2-bit priority fields per word.
// - Smaller priority value wins among enabled pending lines 0-11.
// - Pending and priority words reset to zero.
// - Priority words at 0x400, 0x404, 0x408, read/write.
// - Writing one to pending-set makes line pending.
// - Enable set/clear by ones; both read status.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"
module ipc_top (
  // Clock and reset
  input wire sys_clk,
  input wire arst_n,
  // Register port
  input wire [`IPC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // Peripheral interrupt lines, one-cycle or level requests
  input wire [`IPC_NUM_LINES-1:0] irq_req,
  // Arbitration result
  output reg sel_valid_q,
  output reg [3:0] sel_line_q,
  output reg [7:0] sel_vector_q,
  output reg [`IPC_PRI_W-1:0] sel_prio_q,
  // Event interrupt
  output wire evt_irq
);
  wire wr_pclr = reg_wr && (reg_addr == `IPC_OFF_PENDING_CLEAR);
  wire wr_pset = reg_wr && (reg_addr == `IPC_OFF_PENDING_SET);
  wire wr_eset = reg_wr && (reg_addr == `IPC_OFF_ENABLE_SET);
  wire wr_eclr = reg_wr && (reg_addr == `IPC_OFF_ENABLE_CLEAR);
  wire [`IPC_NUM_LINES-1:0] pend;
  wire [`IPC_NUM_LINES-1:0] ena;
  reg [`IPC_NUM_LINES-1:0] pend_prev_q;
  reg [`IPC_PRI_W-1:0] prio_q [0:`IPC_NUM_PRI_LINES-1];
  wire [`IPC_NUM_PRI_LINES*`IPC_PRI_W-1:0] prio_flat;
  reg [`IPC_EVT_W-1:0] evt_stat_q;
  reg [`IPC_EVT_W-1:0] evt_en_q;
  wire [`IPC_EVT_W-1:0] evt_hit;
  wire win_valid;
  wire [3:0] win_line;
  wire [`IPC_PRI_W-1:0] win_prio;
  reg [31:0] rdata_d;
  integer k;

  genvar g;
  generate
    for (g = 0; g < `IPC_NUM_LINES; g = g + 1) begin : g_line
      // Bit g of every line-wide register is line g.
      ipc_pend_cell u_cell (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hw_req(irq_req[g]),
        .pend_set(wr_pset && reg_wdata[g]),
        .pend_clr(wr_pclr && reg_wdata[g]),
        .ena_set(wr_eset && reg_wdata[g]),
        .ena_clr(wr_eclr && reg_wdata[g]),
        .pend_q(pend[g]),
        .ena_q(ena[g])
      );
    end
    for (g = 0; g < `IPC_NUM_PRI_LINES; g = g + 1) begin : g_prio
      assign prio_flat[g*`IPC_PRI_W +: `IPC_PRI_W] = prio_q[g];
    end
  endgenerate

  // Priority storage: only the top two bits of each byte are kept.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (k = 0; k < `IPC_NUM_PRI_LINES; k = k + 1) begin
        prio_q[k] <= 2'h0;
      end
    end else if (reg_wr) begin
      for (k = 0; k < `IPC_NUM_PRI_LINES; k = k + 1) begin
        if (reg_addr == `IPC_OFF_PRIORITY0 + (k / 4) * 4) begin
          prio_q[k] <= reg_wdata[(k % 4) * 8 + `IPC_PRI_LSB +: `IPC_PRI_W];
        end
      end
    end
  end

  // Events: a line becoming pending, and a pending line removed by software.
  assign evt_hit[`IPC_EVT_PEND_ROSE] = |(pend & ~pend_prev_q);
  assign evt_hit[`IPC_EVT_PEND_CLEARED] = wr_pclr && |(reg_wdata & pend);
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_prev_q <= `IPC_RESET_WORD;
      evt_stat_q <= 2'h0;
      evt_en_q <= 2'h0;
    end else begin
      pend_prev_q <= pend;
      // A new event outranks a clear written in the same cycle.
      if (reg_wr && reg_addr == `IPC_OFF_IRQ_CLEAR) begin
        evt_stat_q <= (evt_stat_q & ~reg_wdata[`IPC_EVT_W-1:0]) | evt_hit;
      end else begin
        evt_stat_q <= evt_stat_q | evt_hit;
      end
      if (reg_wr && reg_addr == `IPC_OFF_IRQ_ENABLE) begin
        evt_en_q <= reg_wdata[`IPC_EVT_W-1:0];
      end
    end
  end
  assign evt_irq = |(evt_stat_q & evt_en_q);

  ipc_arbiter u_arb (
    .active(pend[`IPC_NUM_PRI_LINES-1:0] & ena[`IPC_NUM_PRI_LINES-1:0]),
    .prio_flat(prio_flat),
    .win_valid(win_valid),
    .win_line(win_line),
    .win_prio(win_prio)
  );

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_valid_q <= 1'b0;
      sel_line_q <= 4'h0;
      sel_vector_q <= 8'h00;
      sel_prio_q <= 2'h0;
    end else begin
      sel_valid_q <= win_valid;
      sel_line_q <= win_line;
      sel_vector_q <= win_valid ? (8'd`IPC_VEC_FIRST + {4'h0, win_line}) : 8'h00;
      sel_prio_q <= win_prio;
    end
  end

  // Read mux; unmapped offsets read zero.
  always @* begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      `IPC_OFF_PENDING_CLEAR: rdata_d = pend;
      `IPC_OFF_PENDING_SET: rdata_d = pend;
      `IPC_OFF_ENABLE_SET: rdata_d = ena;
      `IPC_OFF_ENABLE_CLEAR: rdata_d = ena;
      `IPC_OFF_PRIORITY0: rdata_d = {prio_q[3], 6'h00, prio_q[2], 6'h00, prio_q[1], 6'h00, prio_q[0], 6'h00};
      `IPC_OFF_PRIORITY1: rdata_d = {prio_q[7], 6'h00, prio_q[6], 6'h00, prio_q[5], 6'h00, prio_q[4], 6'h00};
      `IPC_OFF_PRIORITY2: rdata_d = {prio_q[11], 6'h00, prio_q[10], 6'h00, prio_q[9], 6'h00, prio_q[8], 6'h00};
      `IPC_OFF_IRQ_STATUS: rdata_d = {30'h0, evt_stat_q};
      `IPC_OFF_IRQ_ENABLE: rdata_d = {30'h0, evt_en_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= `IPC_RESET_WORD;
    end else begin
      reg_rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end
endmodule // ipc_top
`default_nettype wire

/* File: testbench/ipc_props.sv */
// Assertion checker for the pending-clear and priority block.
`timescale 1ns/1ps
`default_nettype none
module ipc_props (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_q,
  // Lines and results
  input wire logic [31:0] irq_req,
  input wire logic sel_valid_q,
  input wire logic [3:0] sel_line_q,
  input wire logic [7:0] sel_vector_q,
  input wire logic [1:0] sel_prio_q,
  input wire logic evt_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_clr_all;
    reg_wr && reg_addr == 12'h280 && reg_wdata == 32'hffff_ffff && irq_req == 32'h0;
  endsequence
  sequence s_set;
    reg_wr && reg_addr == 12'h200;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data outside its slot");
  a_clear_all: assert property (s_clr_all ##1 !reg_wr && irq_req == 32'h0 ##1 s_rd(12'h280) && irq_req == 32'h0
    |=> reg_rdata_q == 32'h0) else $error("pending survived a clear");
  a_set_shows: assert property (s_set ##1 !reg_wr ##1 s_rd(12'h280)
    |=> (reg_rdata_q & $past(reg_wdata, 3)) == $past(reg_wdata, 3)) else $error("set pending not reported");
  a_prio_resv: assert property (reg_rd && reg_addr[11:4] == 8'h40 |=> (reg_rdata_q & 32'h3f3f_3f3f) == 32'h0)
    else $error("reserved priority bits set");
  a_unmapped_zero: assert property (s_rd(12'h7fc) |=> reg_rdata_q == 32'h0) else $error("unmapped read not zero");
  a_vector_map: assert property (sel_valid_q |-> sel_vector_q == {4'h1, sel_line_q})
    else $error("vector not line plus 16");
  a_line_range: assert property (sel_valid_q |-> sel_line_q <= 4'd11) else $error("winner beyond line 11");
  a_idle_vector: assert property (!sel_valid_q |-> sel_vector_q == 8'h0) else $error("vector without winner");
  a_evt_masked: assert property (reg_wr && reg_addr == 12'h608 && reg_wdata[1:0] == 2'b00 |=> !evt_irq)
    else $error("event irq while masked");
endmodule // ipc_props
bind ipc_top ipc_props u_props (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
  .irq_req, .sel_valid_q, .sel_line_q, .sel_vector_q, .sel_prio_q, .evt_irq);
`default_nettype wire

/* File: testbench/ipc_periph.sv */
// Peripheral model that raises interrupt request lines.
`timescale 1ns/1ps
`default_nettype none
module ipc_periph (
  // Clock
  input wire logic sys_clk,
  // Command and request lines
  input wire logic [31:0] fire,
  output logic [31:0] irq_req
);
  // A flop here keeps requests clock aligned, as a real peripheral output would be.
  initial irq_req = 32'h0;
  always @(posedge sys_clk) begin
    irq_req <= fire;
  end
endmodule // ipc_periph
`default_nettype wire

/* File: testbench/ipc_top_test.sv */
// Self-checking testbench for the pending-clear and priority block.
`timescale 1ns/1ps
`default_nettype none
module ipc_top_test;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] fire = 32'h0;
  wire [31:0] reg_rdata_q;
  wire [31:0] irq_req;
  wire sel_valid_q;
  wire evt_irq;
  wire [3:0] sel_line_q;
  wire [7:0] sel_vector_q;
  wire [1:0] sel_prio_q;
  int err_count = 0;
  int total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  ipc_periph u_periph (.sys_clk, .fire, .irq_req);
  ipc_top dut (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .irq_req,
    .sel_valid_q, .sel_line_q, .sel_vector_q, .sel_prio_q, .evt_irq);
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, e);
  endtask
  task automatic sel_chk(input logic [14:0] e);
    @(posedge sys_clk);
    #1;
    chk({17'h0, sel_valid_q, sel_line_q, sel_vector_q, sel_prio_q}, {17'h0, e});
  endtask
  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      rd(12'h400 + 12'(4 * i), 32'h0);
      wr(12'h400 + 12'(4 * i), 32'hffff_ffff);
      rd(12'h400 + 12'(4 * i), 32'hc0c0_c0c0);
    end
    rd(12'h280, 32'h0);
    wr(12'h40c, 32'hffff_ffff);
    rd(12'h40c, 32'h0);
    rd(12'h7fc, 32'h0);
  endtask
  task automatic t_arb;
    wr(12'h100, 32'h0000_0fff);
    wr(12'h404, 32'hc0c0_40c0);
    wr(12'h200, 32'h0000_0024);
    sel_chk({1'b1, 4'd5, 8'd21, 2'd1});
    wr(12'h404, 32'hffff_ffff);
    sel_chk({1'b1, 4'd2, 8'd18, 2'd3});
    wr(12'h280, 32'h0000_0004);
    sel_chk({1'b1, 4'd5, 8'd21, 2'd3});
    wr(12'h280, 32'hffff_ffff);
    rd(12'h280, 32'h0);
  endtask
  task automatic t_pend;
    wr(12'h200, 32'ha5a5_a5a5);
    rd(12'h280, 32'ha5a5_a5a5);
    wr(12'h280, 32'h0000_ffff);
    rd(12'h280, 32'ha5a5_0000);
    rd(12'h180, 32'h0000_0fff);
    wr(12'h180, 32'h0000_0f00);
    rd(12'h100, 32'h0000_00ff);
  endtask
  task automatic t_evt;
    rd(12'h600, 32'h3);
    wr(12'h608, 32'h3);
    chk(evt_irq, 1'b1);
    wr(12'h608, 32'h0);
    chk(evt_irq, 1'b0);
    wr(12'h604, 32'h3);
    rd(12'h600, 32'h0);
    wr(12'h608, 32'h1);
    @(posedge sys_clk);
    fire <= 32'h4000_0000;
    @(posedge sys_clk);
    fire <= 32'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(evt_irq, 1'b1);
    rd(12'h280, 32'he5a5_0000);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // The whole sequence needs under a hundred cycles, so the 2000-cycle limit leaves a wide margin.
  initial begin
    #50000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_arb();
    t_pend();
    t_evt();
    summarize();
  end
endmodule // ipc_top_test
`default_nettype wire
